// ===== t2crc_pkg.sv
// shared constants for the timer 2 capture/reload counter
package t2crc_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] T2CRC_IDX_CONTROL  = 8'hC8;
  localparam logic [7:0] T2CRC_IDX_MODE     = 8'hC9;
  localparam logic [7:0] T2CRC_IDX_CAP_LOW  = 8'hCA;
  localparam logic [7:0] T2CRC_IDX_CAP_HIGH = 8'hCB;
  localparam logic [7:0] T2CRC_IDX_CNT_LOW  = 8'hCC;
  localparam logic [7:0] T2CRC_IDX_CNT_HIGH = 8'hCD;
  localparam logic [7:0] T2CRC_IDX_CLK_CTRL = 8'hCE;

  // control register bit positions
  localparam int T2CRC_B_OVF   = 7;
  localparam int T2CRC_B_EXT   = 6;
  localparam int T2CRC_B_RXSEL = 5;
  localparam int T2CRC_B_TXSEL = 4;
  localparam int T2CRC_B_EXEN  = 3;
  localparam int T2CRC_B_RUN   = 2;
  localparam int T2CRC_B_CTSEL = 1;
  localparam int T2CRC_B_CPRL  = 0;

  // mode register bit positions; bits 7..2 reserved, read zero
  localparam int T2CRC_B_CLKOE = 1;
  localparam int T2CRC_B_DOWN_COUNT_ENABLE  = 0;

  // prescale select position in the clock control register
  localparam int T2CRC_B_PRESC = 5;

  // values after reset
  localparam logic [7:0]  T2CRC_RST_CONTROL = 8'h00;
  localparam logic [1:0]  T2CRC_RST_MODE    = 2'h0;
  localparam logic [15:0] T2CRC_RST_CAPTURE = 16'h0000;
  localparam logic [15:0] T2CRC_RST_COUNT   = 16'h0000;
  localparam logic [15:0] T2CRC_ALL_ONES    = 16'hFFFF;

  // timer tick dividers in core clock cycles
  localparam logic [3:0] T2CRC_DIV_SLOW = 4'hC;
  localparam logic [3:0] T2CRC_DIV_FAST = 4'h4;
endpackage : t2crc_pkg

// ===== t2crc_pin_sync.sv
// three-stage synchroniser with falling-edge pulse for the trigger pin
`timescale 1ns/1ns
module t2crc_pin_sync (
  input  wire logic clk_i,   // core clock
  input  wire logic rst_i,   // synchronous reset, high
  input  wire logic ce_i,    // clock enable
  input  wire logic pin_i,   // asynchronous pin
  output logic      level_o, // filtered level
  output logic      fall_o   // one-cycle pulse on a falling edge
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // the first stage feeds only the second, to keep metastability contained
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
      s3_q    <= 1'b1;
      level_o <= 1'b1;
      fall_o  <= 1'b0;
    end else if (ce_i) begin
      s1_q   <= pin_i;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      fall_o <= 1'b0;
      if (s2_q == s3_q) begin // change accepted once two stages agree
        level_o <= s3_q;
        fall_o  <= level_o & ~s3_q;
      end
    end
  end
endmodule : t2crc_pin_sync

// ===== t2crc_timer.sv
// timer 2: 16-bit counter with capture, auto-reload and baud time base
//
// How it works
// - overflow or down-count match sets overflow flag outside baud mode
// - trigger falling edge with enable and no down-count sets external flag outside baud mode
// - receive select picks this overflow as receive tick, else timer one
// - transmit select picks this overflow as transmit tick, else timer one
// - outside baud mode, trigger enable lets pin edges capture or reload
// - run bit off stops counting; an enabled pin-edge reload still loads both count bytes
// - counter select zero counts prescaled ticks, one counts pin edges
// - reload select zero reloads from capture pair on overflow or pin edge
// - capture select one with enable copies the count on each pin edge
// - any baud select forces auto-reload and ignores the capture select
// - clock-out enable bit turns the toggling clock output on or off
// - down-count enable lets the pin level pick direction in auto-reload outside baud mode
// - capture low byte takes count low byte, supplies low reload byte
// - capture high byte takes count high byte, supplies high reload byte
`timescale 1ns/1ns
module t2crc_timer
  import t2crc_pkg::*;
(
  input  wire logic        clk_i,        // core clock, 100 MHz
  input  wire logic        rst_i,        // synchronous reset, high
  input  wire logic        ce_i,         // clock enable, freezes all
  input  wire logic        wb_cyc_i,     // wishbone cycle
  input  wire logic        wb_stb_i,     // wishbone strobe
  input  wire logic        wb_we_i,      // wishbone write
  input  wire logic [11:0] wb_adr_i,     // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,     // wishbone byte selects
  input  wire logic [31:0] wb_dat_i,     // wishbone write data
  output logic      [31:0] wb_dat_o,     // wishbone read data
  output logic             wb_ack_o,     // wishbone acknowledge
  input  wire logic        trigger_pin_i, // external trigger pin
  input  wire logic        timer1_ovf_i, // other timer overflow pulse
  output logic             rx_tick_o,    // serial receive time base
  output logic             tx_tick_o,    // serial transmit time base
  output logic             clk_out_o,    // clock-out level
  output logic             clk_out_oe_o, // clock-out drive enable
  output logic             ovf_flag_o,   // overflow flag level
  output logic             ext_flag_o    // external event flag level
);
  logic [7:0]  ctrl_q;
  logic [1:0]  mode_q;
  logic        presc_q;
  logic [15:0] cap_q;
  logic [15:0] cnt_q;
  logic [3:0]  pre_q;
  logic        ack_q;
  logic [7:0]  rdat_q;
  logic        trig_lvl;
  logic        trig_fall;

  // trigger pin enters through three flip-flops
  t2crc_pin_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .pin_i   (trigger_pin_i),
    .level_o (trig_lvl),
    .fall_o  (trig_fall)
  );

  // decoded control fields
  logic rx_sel;
  logic tx_sel;
  logic baud;
  logic exen;
  logic run;
  logic cts;
  logic cprl;
  logic down_count_enable;
  logic autoreload;
  logic down_mode;
  assign rx_sel     = ctrl_q[T2CRC_B_RXSEL];
  assign tx_sel     = ctrl_q[T2CRC_B_TXSEL];
  assign baud       = rx_sel | tx_sel;
  assign exen       = ctrl_q[T2CRC_B_EXEN];
  assign run        = ctrl_q[T2CRC_B_RUN];
  assign cts        = ctrl_q[T2CRC_B_CTSEL];
  assign cprl       = ctrl_q[T2CRC_B_CPRL];
  assign down_count_enable       = mode_q[T2CRC_B_DOWN_COUNT_ENABLE];
  assign autoreload = baud | ~cprl;
  assign down_mode  = down_count_enable & autoreload & ~baud;

  // bus decode: one register per aligned word, data in byte lane 0
  logic [7:0] idx;
  logic       req;
  logic       wr;
  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i & wb_stb_i;
  // a write lands only on the edge where ack is seen by the master
  assign wr  = req & wb_we_i & ack_q & wb_sel_i[0];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r) & (wb_adr_i[11:10] == 2'h0);
  endfunction : hit

  logic wr_ctrl;
  logic wr_cap_l;
  logic wr_cap_h;
  logic wr_cnt_l;
  logic wr_cnt_h;
  logic wr_cnt;
  logic wr_cap;
  assign wr_ctrl  = wr & hit(idx, T2CRC_IDX_CONTROL);
  assign wr_cap_l = wr & hit(idx, T2CRC_IDX_CAP_LOW);
  assign wr_cap_h = wr & hit(idx, T2CRC_IDX_CAP_HIGH);
  assign wr_cnt_l = wr & hit(idx, T2CRC_IDX_CNT_LOW);
  assign wr_cnt_h = wr & hit(idx, T2CRC_IDX_CNT_HIGH);
  assign wr_cnt   = wr_cnt_l | wr_cnt_h;
  assign wr_cap   = wr_cap_l | wr_cap_h;

  // prescaler: slow or fast tick picked by the clock control bit
  logic [3:0] div;
  logic       pre_tick;
  assign div      = presc_q ? T2CRC_DIV_FAST : T2CRC_DIV_SLOW;
  assign pre_tick = (pre_q == div - 4'h1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q <= 4'h0;
    end else if (ce_i) begin
      pre_q <= pre_tick ? 4'h0 : pre_q + 4'h1;
    end
  end

  // counting events and their consequences
  logic count_en;
  logic up;
  logic ovf_up;
  logic down_hit;
  logic ovf;
  logic ext_evt;
  logic do_reload;
  logic do_capture;
  // source is prescaled clock or pin edges; run bit gates both
  assign count_en   = run & (cts ? trig_fall : pre_tick);
  assign up         = ~down_mode | trig_lvl;
  assign ovf_up     = count_en & up & (cnt_q == T2CRC_ALL_ONES);
  assign down_hit   = count_en & ~up & (cnt_q == cap_q);
  assign ovf        = ovf_up | down_hit;
  // in down-count mode the pin is the direction, not a trigger
  assign ext_evt    = trig_fall & exen & ~baud;
  assign do_reload  = (autoreload & ovf_up) |
                      (ext_evt & ~cprl & ~down_mode);
  assign do_capture = ext_evt & cprl & ~baud;

  // counter: software write wins over counting in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= T2CRC_RST_COUNT;
    end else if (ce_i) begin
      if (wr_cnt) begin
        if (wr_cnt_l) cnt_q[7:0]  <= wb_dat_i[7:0];
        if (wr_cnt_h) cnt_q[15:8] <= wb_dat_i[7:0];
      end else if (do_reload) begin
        cnt_q <= cap_q;
      end else if (down_hit) begin
        cnt_q <= T2CRC_ALL_ONES;
      end else if (count_en) begin
        cnt_q <= up ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
      end
    end
  end

  // capture pair: doubles as the reload value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_q <= T2CRC_RST_CAPTURE;
    end else if (ce_i) begin
      if (wr_cap_l) cap_q[7:0]  <= wb_dat_i[7:0];
      else if (do_capture) cap_q[7:0] <= cnt_q[7:0];
      if (wr_cap_h) cap_q[15:8] <= wb_dat_i[7:0];
      else if (do_capture) cap_q[15:8] <= cnt_q[15:8];
    end
  end

  // control register: hardware flag set beats a software clear
  logic set_ovf;
  logic set_ext;
  assign set_ovf = ovf & ~baud;
  assign set_ext = ext_evt & ~down_count_enable;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= T2CRC_RST_CONTROL;
    end else if (ce_i) begin
      if (wr_ctrl) ctrl_q <= wb_dat_i[7:0];
      if (set_ovf) ctrl_q[T2CRC_B_OVF] <= 1'b1;
      if (set_ext) ctrl_q[T2CRC_B_EXT] <= 1'b1;
    end
  end

  // mode and clock control registers, written only by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q  <= T2CRC_RST_MODE;
      presc_q <= 1'b0;
    end else if (ce_i) begin
      if (wr & hit(idx, T2CRC_IDX_MODE)) mode_q <= wb_dat_i[1:0];
      if (wr & hit(idx, T2CRC_IDX_CLK_CTRL)) begin
        presc_q <= wb_dat_i[T2CRC_B_PRESC];
      end
    end
  end

  // serial time bases registered so the ticks leave from flip-flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_tick_o <= 1'b0;
      tx_tick_o <= 1'b0;
    end else if (ce_i) begin
      rx_tick_o <= rx_sel ? ovf : timer1_ovf_i;
      tx_tick_o <= tx_sel ? ovf : timer1_ovf_i;
    end
  end

  // clock-out toggles on each overflow while enabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_out_o <= 1'b0;
    end else if (ce_i) begin
      if (!mode_q[T2CRC_B_CLKOE]) clk_out_o <= 1'b0;
      else if (ovf) clk_out_o <= ~clk_out_o;
    end
  end

  assign clk_out_oe_o = mode_q[T2CRC_B_CLKOE];
  assign ovf_flag_o   = ctrl_q[T2CRC_B_OVF];
  assign ext_flag_o   = ctrl_q[T2CRC_B_EXT];

  // read mux; unmapped indices read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (hit(idx, T2CRC_IDX_CONTROL))  rd_mux = ctrl_q;
    if (hit(idx, T2CRC_IDX_MODE))     rd_mux = {6'h00, mode_q};
    if (hit(idx, T2CRC_IDX_CAP_LOW))  rd_mux = cap_q[7:0];
    if (hit(idx, T2CRC_IDX_CAP_HIGH)) rd_mux = cap_q[15:8];
    if (hit(idx, T2CRC_IDX_CNT_LOW))  rd_mux = cnt_q[7:0];
    if (hit(idx, T2CRC_IDX_CNT_HIGH)) rd_mux = cnt_q[15:8];
    if (hit(idx, T2CRC_IDX_CLK_CTRL)) rd_mux = {2'h0, presc_q, 5'h00};
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 8'h00;
    end else if (ce_i) begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) rdat_q <= rd_mux;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = {24'h000000, rdat_q};

  // overflow flag follows its cause by one cycle
  ovf_flag_set_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && ovf && !baud |=> ovf_flag_o)
    else $error("overflow did not set the overflow flag");

  // external flag follows a qualified pin edge
  ext_flag_set_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && ext_evt && !down_count_enable |=> ext_flag_o)
    else $error("pin edge did not set the external flag");

  // receive tick comes from this timer when selected
  rx_base_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && rx_sel && ovf |=> rx_tick_o)
    else $error("receive tick missed this timer overflow");

  // transmit tick follows the other timer when not selected
  tx_base_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && !tx_sel |=> tx_tick_o == $past(timer1_ovf_i))
    else $error("transmit tick not from the other timer");

  // without trigger enable the capture pair only changes by software
  no_trigger_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && !exen && !wr_cap |=> $stable(cap_q))
    else $error("capture pair changed with trigger disabled");

  // stopped counter holds both bytes unless written or reloaded
  stop_hold_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && !run && !wr_cnt && !do_reload |=> $stable(cnt_q))
    else $error("stopped counter moved");

  // in counter mode nothing counts without a pin edge
  edge_count_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && cts && !trig_fall && !wr_cnt |=> $stable(cnt_q))
    else $error("counter mode moved without a pin edge");

  // capture copies the count into the pair
  capture_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && do_capture && !wr_cap |=> cap_q == $past(cnt_q))
    else $error("capture did not copy the count");

  // up overflow reloads, and flags outside baud mode
  reload_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && ovf_up && autoreload && !wr_cnt && !wr_cap
    |=> cnt_q == $past(cap_q) && (ovf_flag_o || baud))
    else $error("overflow did not reload from capture pair");

  // clock-out toggles on overflow while enabled
  clk_toggle_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && clk_out_oe_o && ovf |=> clk_out_o != $past(clk_out_o))
    else $error("clock-out did not toggle on overflow");

  // low pin level counts down in down-count mode
  down_dir_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && count_en && !up && !down_hit && !wr_cnt && !do_reload
    |=> cnt_q == $past(cnt_q) - 16'h0001)
    else $error("down-count step wrong");

  // a qualified pin edge in reload mode loads the capture pair
  pin_reload_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && ext_evt && !cprl && !down_mode && !wr_cnt
    |=> cnt_q == $past(cap_q))
    else $error("pin edge did not reload the counter");

  // baud mode reloads on overflow even with capture selected
  baud_reload_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && baud && ovf_up && !wr_cnt |=> cnt_q == $past(cap_q))
    else $error("baud overflow did not reload");

  // down-count match wraps to all ones and raises the flag
  down_match_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && down_hit && !wr_cnt
    |=> cnt_q == T2CRC_ALL_ONES && ovf_flag_o)
    else $error("down-count match did not wrap and flag");

  // external flag moves only by software while the enable is off
  ext_flag_hold_a : assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && !exen && !wr_ctrl |=> $stable(ext_flag_o))
    else $error("external flag moved with trigger disabled");
endmodule : t2crc_timer

// ===== t2crc_far_side.sv
// far side model: trigger pin driver, other timer, serial tick counters
`timescale 1ns/1ns
module t2crc_far_side (
  input  wire logic        clk_i,     // core clock
  input  wire logic        rst_i,     // synchronous reset, high
  input  wire logic        pin_req_i, // pin level asked by the bench
  input  wire logic        rx_tick_i, // receive time base from timer
  input  wire logic        tx_tick_i, // transmit time base from timer
  output logic             pin_o,     // trigger pin level
  output logic             t1_ovf_o,  // other timer overflow pulse
  output logic [15:0]      rx_cnt_o,  // receive ticks seen
  output logic [15:0]      tx_cnt_o   // transmit ticks seen
);
  logic [2:0] t1_div_q;

  // other timer overflows every seventh cycle, a rate unlike timer 2's
  always_ff @(posedge clk_i) begin
    if (rst_i || t1_div_q == 3'h6) begin
      t1_div_q <= 3'h0;
    end else begin
      t1_div_q <= t1_div_q + 3'h1;
    end
    t1_ovf_o <= !rst_i && t1_div_q == 3'h6;
  end

  // pin idles high, as a pulled-up trigger line would
  always_ff @(posedge clk_i) begin
    pin_o <= rst_i ? 1'b1 : pin_req_i;
  end

  // serial port side only counts the time base pulses it receives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_cnt_o <= 16'h0000;
      tx_cnt_o <= 16'h0000;
    end else begin
      rx_cnt_o <= rx_cnt_o + {15'h0000, rx_tick_i};
      tx_cnt_o <= tx_cnt_o + {15'h0000, tx_tick_i};
    end
  end
endmodule : t2crc_far_side

// ===== t2crc_timer_bench.sv
// self-checking bench for the timer 2 capture/reload counter
`timescale 1ns/1ns
module t2crc_timer_bench import t2crc_pkg::*;;
  logic        clk_i, rst_i, cyc, stb, we, pin_req, pin, t1_ovf;
  logic        ack, rx_tick, tx_tick, clk_out, clk_oe, ovf, ext;
  logic [11:0] adr;
  logic [31:0] wdat, rdat;
  logic [15:0] rx_cnt, tx_cnt, r0, t0, own, oth;
  logic [7:0]  rd, h0, hi [2];
  int          n_errors = 0, n_checks = 0, cycles = 0, toggles = 0;

  t2crc_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .trigger_pin_i(pin), .timer1_ovf_i(t1_ovf), .rx_tick_o(rx_tick),
    .tx_tick_o(tx_tick), .clk_out_o(clk_out), .clk_out_oe_o(clk_oe),
    .ovf_flag_o(ovf), .ext_flag_o(ext));

  t2crc_far_side far_u (.clk_i(clk_i), .rst_i(rst_i), .pin_req_i(pin_req),
    .rx_tick_i(rx_tick), .tx_tick_i(tx_tick), .pin_o(pin),
    .t1_ovf_o(t1_ovf), .rx_cnt_o(rx_cnt), .tx_cnt_o(tx_cnt));

  // clock, 10 ns period
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // hang guard, far above the nine hundred or so cycles the tests take
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  // rising edges of the clock-out pin
  always @(posedge clk_out) toggles++;

  task check(input string what, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one classic wishbone cycle; waits up to 50 cycles for ack, then flags an error
  task xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {2'h0, idx, 2'h0};
    wdat <= {24'h000000, wd};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) check("bus ack", 16'h0000, 16'h0001);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask : wr

  task rdc(input string what, input logic [7:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    check(what, {8'h00, rd}, {8'h00, e});
  endtask : rdc

  // 16-bit values go low byte first; halves are not latched together
  task pair(input logic [7:0] idx, input logic [15:0] v);
    wr(idx, v[7:0]);
    wr(idx + 8'h01, v[15:8]);
  endtask : pair

  // edge reaches the logic some four cycles later through the synchroniser
  task pin_fall();
    pin_req <= 1'b0;
    repeat (8) @(posedge clk_i);
    pin_req <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask : pin_fall

  task end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    {cyc, stb, we, pin_req, rst_i} = 5'b00011;
    adr = 12'h000;
    wdat = 32'h00000000;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("control", T2CRC_IDX_CONTROL, T2CRC_RST_CONTROL);
    wr(T2CRC_IDX_MODE, 8'hFF);
    rdc("mode", T2CRC_IDX_MODE, 8'h03);
    check("clock out enable", clk_oe, 1'b1);
    rdc("unmapped", 8'hD0, 8'h00);
    wr(T2CRC_IDX_MODE, 8'h00);
    $display("test registers done");
    // overflow past all ones, fast prescale
    pair(T2CRC_IDX_CAP_LOW, 16'h1234);
    pair(T2CRC_IDX_CNT_LOW, 16'hFFF0);
    wr(T2CRC_IDX_CLK_CTRL, 8'h20);
    wr(T2CRC_IDX_CONTROL, 8'h04);
    for (int i = 0; i < 200 && ovf !== 1'b1; i++) @(posedge clk_i);
    check("overflow flag", ovf, 1'b1);
    wr(T2CRC_IDX_CONTROL, 8'h00);
    // the flag bit changes on the write edge; look one edge later
    @(posedge clk_i);
    check("flag cleared", ovf, 1'b0);
    rdc("reloaded high", T2CRC_IDX_CNT_HIGH, 8'h12);
    xfer(1'b0, T2CRC_IDX_CNT_LOW, 8'h00);
    h0 = rd;
    repeat (20) @(posedge clk_i);
    rdc("stopped low", T2CRC_IDX_CNT_LOW, h0);
    wr(T2CRC_IDX_CONTROL, 8'h80);
    @(posedge clk_i);
    check("flag set by write", ovf, 1'b1);
    $display("test overflow done");
    // capture, then enable off, then reload on pin edge
    pair(T2CRC_IDX_CNT_LOW, 16'hABCD);
    wr(T2CRC_IDX_CONTROL, 8'h09);
    pin_fall();
    check("external flag", ext, 1'b1);
    rdc("capture low", T2CRC_IDX_CAP_LOW, 8'hCD);
    rdc("capture high", T2CRC_IDX_CAP_HIGH, 8'hAB);
    wr(T2CRC_IDX_CONTROL, 8'h01);
    pair(T2CRC_IDX_CNT_LOW, 16'h5555);
    pin_fall();
    rdc("no capture", T2CRC_IDX_CAP_LOW, 8'hCD);
    check("external flag off", ext, 1'b0);
    wr(T2CRC_IDX_CONTROL, 8'h08);
    pair(T2CRC_IDX_CNT_LOW, 16'h0000);
    pin_fall();
    rdc("pin reload high", T2CRC_IDX_CNT_HIGH, 8'hAB);
    rdc("pin reload low", T2CRC_IDX_CNT_LOW, 8'hCD);
    $display("test capture done");
    // counter mode counts pin falling edges
    wr(T2CRC_IDX_CONTROL, 8'h00);
    pair(T2CRC_IDX_CNT_LOW, 16'h0000);
    wr(T2CRC_IDX_CONTROL, 8'h06);
    repeat (3) pin_fall();
    wr(T2CRC_IDX_CONTROL, 8'h00);
    rdc("edge count", T2CRC_IDX_CNT_LOW, 8'h03);
    $display("test counter done");
    // baud modes: overflow every 8 cycles, other timer every 7
    wr(T2CRC_IDX_MODE, 8'h02);
    pair(T2CRC_IDX_CAP_LOW, 16'hFFFE);
    pair(T2CRC_IDX_CNT_LOW, 16'hFFFE);
    for (int k = 0; k < 2; k++) begin
      wr(T2CRC_IDX_CONTROL, k ? 8'h15 : 8'h25);
      r0 = rx_cnt;
      t0 = tx_cnt;
      toggles = 0;
      repeat (200) @(posedge clk_i);
      own = k ? tx_cnt - t0 : rx_cnt - r0;
      oth = k ? rx_cnt - r0 : tx_cnt - t0;
      check("own ticks", own >= 24 && own <= 26, 1'b1);
      check("others", oth >= 27 && oth <= 30, 1'b1);
      check("baud flag", ovf, 1'b0);
      check("clock out", toggles >= 11 && toggles <= 14, 1'b1);
    end
    wr(T2CRC_IDX_MODE, 8'h00);
    // clock-out is forced low one cycle after the enable bit drops
    repeat (2) @(posedge clk_i);
    check("clock out off", {clk_oe, clk_out}, 2'b00);
    $display("test baud done");
    // down-count: pin low counts down to the capture value, then wraps
    wr(T2CRC_IDX_MODE, 8'h01);
    pair(T2CRC_IDX_CAP_LOW, 16'h00F8);
    for (int k = 0; k < 2; k++) begin
      wr(T2CRC_IDX_CONTROL, 8'h00);
      pin_req <= k[0];
      pair(T2CRC_IDX_CNT_LOW, 16'h0100);
      wr(T2CRC_IDX_CONTROL, 8'h04);
      repeat (40) @(posedge clk_i);
      h0[k] = ovf;
      wr(T2CRC_IDX_CONTROL, 8'h00);
      xfer(1'b0, T2CRC_IDX_CNT_HIGH, 8'h00);
      hi[k] = rd;
    end
    check("down match flag", h0[1:0], 2'b01);
    check("direction", {hi[0], hi[1]}, 16'hFF01);
    $display("test down count done");
    end_of_test();
  end
endmodule : t2crc_timer_bench
